/* rtl/fsp_host.sv */
// Host controller that configures the flash status output pin
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
// Function
// - Write 00B8h setup, then configuration code
// - Configure only when ready flag set
// - Upper six code bits reserved, cleared
// - Confirm cycle at same die address
module fsp_host
    import fsp_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [15:0] i_fl_dq,
    output logic [15:0]      o_fl_dq,
    output logic             o_fl_dq_oe,
    output logic             o_fl_ce_n,
    output logic             o_fl_we_n,
    output logic             o_fl_oe_n
);
    // ==========================================================
    // State
    fsp_state_t  state,   next_state;
    logic [4:0]  cnt,     next_cnt;
    logic [7:0]  code,    next_code;
    logic        busy,    next_busy;
    logic        done,    next_done;
    logic        err,     next_err;
    logic        rej,     next_rej;
    logic [7:0]  sr,      next_sr;
    logic [1:0]  phase,   next_phase;
    logic [15:0] dq,      next_dq;
    logic        dq_oe,   next_dq_oe;
    logic        we_n,    next_we_n;
    logic        oe_n,    next_oe_n;
    logic        ce_n,    next_ce_n;
    logic        ready,   next_ready;
    logic [31:0] rdata,   next_rdata;
    logic        wr_ctrl;
    logic        cyc_end;

    assign wr_ctrl = psel && penable && pready && pwrite
                     && paddr == ADDR_CTRL;
    assign cyc_end = cnt == CYCLE_LAST;

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_cnt   = cyc_end ? 5'h00 : cnt + 5'h01;
        next_code  = code;
        next_busy  = busy;
        next_done  = done;
        next_err   = err;
        next_rej   = rej;
        next_sr    = sr;
        next_phase = phase;
        next_dq    = dq;
        next_dq_oe = dq_oe;
        next_we_n  = 1'b1;
        next_oe_n  = 1'b1;
        next_ce_n  = 1'b1;
        case (state)
            FSP_IDLE: begin
                next_cnt = 5'h00;
                if (wr_ctrl && pwdata[CTRL_START_BIT] && !busy) begin
                    // Reserved bits always sent as zero
                    next_code = pwdata[CTRL_CODE_MSB:0] & CODE_MASK;
                    next_done = 1'b0;
                    next_err  = 1'b0;
                    next_rej  = 1'b0;
                    if ((pwdata[1:0] == CODE_PROG_ONLY)
                        && !pwdata[CTRL_AUTO_BIT]) begin
                        next_rej  = 1'b1;
                        next_done = 1'b1;
                    end else begin
                        next_busy  = 1'b1;
                        next_state = FSP_POLL;
                    end
                end
            end
            FSP_POLL, FSP_CHECK: begin
                // Read status: first half writes 70h, second reads
                next_ce_n = cyc_end;
                if (phase == 2'h0) begin
                    next_we_n  = cyc_end;
                    next_dq    = CMD_READ_STAT;
                    next_dq_oe = !cyc_end;
                end else begin
                    next_oe_n  = cyc_end;
                    next_dq_oe = 1'b0;
                end
                if (cyc_end) begin
                    next_phase = phase + 2'h1;
                    if (phase == 2'h1) begin
                        next_phase = 2'h0;
                        next_sr    = i_fl_dq[7:0];
                        if (state == FSP_POLL) begin
                            if (i_fl_dq[SR_READY_BIT])
                                next_state = FSP_SETUP;
                        end else if (i_fl_dq[SR_READY_BIT]) begin
                            next_state = FSP_VERIFY;
                        end
                    end
                end
            end
            FSP_SETUP: begin
                next_ce_n  = cyc_end;
                next_we_n  = cyc_end;
                next_dq    = CMD_CFG_SETUP;
                next_dq_oe = !cyc_end;
                if (cyc_end)
                    next_state = FSP_CONF;
            end
            FSP_CONF: begin
                // Same address kept for confirm
                next_ce_n  = cyc_end;
                next_we_n  = cyc_end;
                next_dq    = {8'h00, code};
                next_dq_oe = !cyc_end;
                if (cyc_end)
                    next_state = FSP_CHECK;
            end
            FSP_VERIFY: begin
                // Both error flags mark a rejected code
                next_err   = sr[SR_PROG_ERR] && sr[SR_ERASE_ERR];
                next_done  = 1'b1;
                next_busy  = 1'b0;
                next_state = FSP_IDLE;
            end
            default: begin
                next_state = FSP_IDLE;
            end
        endcase
    end

    // ==========================================================
    // APB slave
    always_comb begin
        next_ready = psel && !pready;
        next_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:   next_rdata = {24'h000000, code};
            ADDR_STAT:   next_rdata = {28'h0000000, rej, err, done, busy};
            ADDR_RESULT: next_rdata = {24'h000000, sr};
            default:     next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= FSP_IDLE;
            cnt   <= 5'h00;
            code  <= 8'h00;
            busy  <= 1'b0;
            done  <= 1'b0;
            err   <= 1'b0;
            rej   <= 1'b0;
            sr    <= 8'h00;
            phase <= 2'h0;
            dq    <= 16'h0000;
            dq_oe <= 1'b0;
            we_n  <= 1'b1;
            oe_n  <= 1'b1;
            ce_n  <= 1'b1;
            ready <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            code  <= next_code;
            busy  <= next_busy;
            done  <= next_done;
            err   <= next_err;
            rej   <= next_rej;
            sr    <= next_sr;
            phase <= next_phase;
            dq    <= next_dq;
            dq_oe <= next_dq_oe;
            we_n  <= next_we_n;
            oe_n  <= next_oe_n;
            ce_n  <= next_ce_n;
            ready <= next_ready;
            rdata <= next_rdata;
        end
    end

    assign pready     = ready;
    assign prdata     = rdata;
    assign pslverr    = 1'b0;
    assign o_fl_dq    = dq;
    assign o_fl_dq_oe = dq_oe;
    assign o_fl_ce_n  = ce_n;
    assign o_fl_we_n  = we_n;
    assign o_fl_oe_n  = oe_n;

    // ==========================================================
    // Assertions
    a_setup_before_conf: assert property (
        @(posedge i_clk) disable iff (i_rst)
        state == FSP_CONF && $past(state) != FSP_CONF
        |-> $past(dq) == CMD_CFG_SETUP)
        else $error("Confirm not preceded by setup data");
    a_poll_ready: assert property (
        @(posedge i_clk) disable iff (i_rst)
        state == FSP_SETUP && $past(state) == FSP_POLL
        |-> sr[SR_READY_BIT])
        else $error("Setup issued while flash busy");
    a_code_reserved: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (code & ~CODE_MASK) == 8'h00)
        else $error("Reserved code bits sent");
    a_err_both: assert property (
        @(posedge i_clk) disable iff (i_rst)
        state == FSP_VERIFY |=> err == (sr[SR_PROG_ERR] && sr[SR_ERASE_ERR]))
        else $error("Error flag not from both status bits");
    a_we_pulse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(we_n) |-> !we_n [*8])
        else $error("Write strobe too short");
    a_no_drive_read: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !oe_n |-> !dq_oe)
        else $error("Bus contention during read");
    a_prog_only: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_ctrl && pwdata[CTRL_START_BIT] && state == FSP_IDLE
        && pwdata[1:0] == CODE_PROG_ONLY && !pwdata[CTRL_AUTO_BIT]
        |=> state == FSP_IDLE && rej)
        else $error("Program only code sent");
    a_apb_ready: assert property (@(posedge i_clk) disable iff (i_rst)
        psel && !penable |=> pready)
        else $error("APB ready late");
endmodule : fsp_host

/* pkg/fsp_pkg.sv */
// Constants shared by the status pin configuration host controller
package fsp_pkg;
    // APB register offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STAT     = 8'h04;
    localparam logic [7:0]  ADDR_RESULT   = 8'h08;
    // Control register fields
    localparam int          CTRL_START_BIT = 8;
    localparam int          CTRL_CODE_MSB  = 7;
    localparam int          CTRL_AUTO_BIT  = 9;
    // Flash command and status bits
    localparam logic [15:0] CMD_CFG_SETUP  = 16'h00B8;
    localparam logic [15:0] CMD_READ_STAT  = 16'h0070;
    localparam int          SR_READY_BIT   = 7;
    localparam int          SR_ERASE_ERR   = 5;
    localparam int          SR_PROG_ERR    = 4;
    localparam logic [7:0]  CODE_MASK      = 8'h03;
    localparam logic [1:0]  CODE_PROG_ONLY = 2'h2;
    // Bus cycle timing
    localparam int          CLK_NS         = 4;
    localparam int          CYCLE_NS       = 80;
    localparam int          CYCLE_CNT      = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0]  CYCLE_LAST     = 5'(CYCLE_CNT - 1);
    typedef enum logic [2:0] {
        FSP_IDLE   = 3'h0,
        FSP_POLL   = 3'h1,
        FSP_SETUP  = 3'h3,
        FSP_CONF   = 3'h2,
        FSP_CHECK  = 3'h6,
        FSP_VERIFY = 3'h7
    } fsp_state_t;
endpackage : fsp_pkg

/* test/fsp_flash_model.sv */
// Behavioural flash device answering the status pin configuration
`timescale 1ns/10ps
module fsp_flash_model
    import fsp_pkg::*;
(
    input  wire logic        i_rst_n,
    input  wire logic        i_busy,
    input  wire logic        i_susp,
    input  wire logic        i_erase,
    input  wire logic        i_lock,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic [15:0] i_dq,
    output logic [15:0]      o_dq,
    output logic             o_sts
);
    // ======
    // Command decode
    logic [7:0]  sr    = 8'h00;
    logic [15:0] wd    = 16'h0000;
    logic [15:0] conf  = 16'h0000;
    logic [1:0]  cfg   = 2'h0;
    logic        armed = 1'b0;
    logic        wv    = 1'b0;
    logic        viol  = 1'b0;
    logic        pulse = 1'b0;
    logic        rdy;
    int          nwr   = 0;
    // Data taken once strobe and bus have settled
    always @(negedge i_we_n) begin
        #1;
        if (!i_we_n && !i_ce_n) begin
            wd = i_dq;
            wv = 1'b1;
        end
    end
    always @(posedge i_we_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg = 2'h0;
            sr = 8'h00;
            conf = 16'h0000;
            {armed, wv, viol, pulse} = 4'h0;
            nwr = 0;
        end else if (wv) begin
            wv = 1'b0;
            nwr++;
            if (armed) begin
                armed = 1'b0;
                conf = wd;
                if (wd[1:0] == CODE_PROG_ONLY) sr[5:4] = 2'h3;
                else cfg = wd[1:0];
            end else if (wd == CMD_CFG_SETUP) begin
                armed = 1'b1;
                viol |= i_busy;
            end
        end
    end
    // ======
    // Status pin and read data
    assign rdy = !i_busy || i_susp;
    // Lock operations never pulse; bit 0 erase, bit 1 program
    always @(negedge i_busy) begin
        if (!i_lock && (i_erase ? cfg[0] : cfg[1])) begin
            pulse = 1'b1;
            #500 pulse = 1'b0;
        end
    end
    assign o_sts = (cfg == 2'h0) ? rdy : !pulse;
    assign o_dq = {8'h00, rdy, sr[6:0]} ^ {16{i_ce_n | i_oe_n}};
endmodule : fsp_flash_model

/* test/testbench.sv */
// Self-checking bench for the status pin configuration controller
`timescale 1ns/10ps
module testbench
    import fsp_pkg::*;
();
    logic        i_clk;
    logic        i_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        fl_busy;
    logic        fl_susp;
    logic        fl_erase;
    logic        fl_lock;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        sts;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [15:0] host_dq;
    logic [15:0] dev_dq;
    int          n_mismatch;
    int          compares;
    wire  [15:0] fl_dq = dq_oe ? host_dq : dev_dq;
    fsp_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(), .i_fl_dq(fl_dq),
        .o_fl_dq(host_dq), .o_fl_dq_oe(dq_oe), .o_fl_ce_n(ce_n),
        .o_fl_we_n(we_n), .o_fl_oe_n(oe_n));
    fsp_flash_model flash_u (.i_rst_n(!i_rst), .i_busy(fl_busy),
        .i_susp(fl_susp), .i_erase(fl_erase), .i_lock(fl_lock),
        .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_dq(fl_dq),
        .o_dq(dev_dq), .o_sts(sts));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // ======
    // Shared tasks
    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    task automatic run(input logic [31:0] c, output logic [31:0] s);
        apb(1'b1, ADDR_CTRL, c, s);
        do apb(1'b0, ADDR_STAT, 32'h0, s); while (s[1:0] !== 2'b10);
    endtask : run
    // ======
    // Scenarios
    task automatic t_reset();
        logic [31:0] r;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0, r);
            chk(r, 32'h0);
        end
        chk(32'(sts), 32'h1);
    endtask : t_reset
    task automatic t_codes();
        logic [31:0] s;
        logic [31:0] c [3] = '{32'h1FD, 32'h103, 32'h100};
        fl_busy <= 1'b1;
        fork
            begin
                repeat (300) @(posedge i_clk);
                fl_busy <= 1'b0;
            end
        join_none
        for (int i = 0; i < 3; i++) begin
            run(c[i], s);
            chk(s, 32'h2);
            chk(32'(flash_u.cfg), 32'(c[i][1:0]));
            chk(32'(flash_u.conf), 32'(c[i][1:0]));
            chk(32'(flash_u.viol), 32'h0);
            apb(1'b0, ADDR_RESULT, 32'h0, s);
            chk(s, 32'h80);
        end
    endtask : t_codes
    task automatic t_pin();
        logic [31:0] s;
        fl_busy <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h0);
        fl_susp <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h1);
        fl_susp <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h0);
        fl_busy <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h1);
        run(32'h101, s);
        chk(32'(flash_u.cfg), 32'h1);
        // Locked erase, program, then plain erase completion
        for (int k = 0; k < 3; k++) begin
            fl_lock <= (k == 0);
            fl_erase <= (k != 1);
            fl_busy <= 1'b1;
            repeat (2) @(posedge i_clk);
            fl_busy <= 1'b0;
            repeat (2) @(posedge i_clk);
            chk(32'(sts), 32'(k != 2));
        end
        repeat (130) @(posedge i_clk);
        chk(32'(sts), 32'h1);
        fl_erase <= 1'b0;
        run(32'h100, s);
        chk(32'(flash_u.cfg), 32'h0);
    endtask : t_pin
    task automatic t_refuse();
        logic [31:0] s;
        int          n;
        n = flash_u.nwr;
        run(32'h102, s);
        chk(s, 32'hA);
        chk(32'(flash_u.nwr), 32'(n));
    endtask : t_refuse
    task automatic t_rst_mid();
        logic [31:0] s;
        run(32'h103, s);
        fl_busy <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h1);
        fl_busy <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(32'(sts), 32'h0);
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk(32'(flash_u.cfg), 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0, s);
        chk(s, 32'h0);
    endtask : t_rst_mid
    task automatic t_force();
        logic [31:0] s;
        run(32'h302, s);
        chk(s, 32'h6);
        chk(32'(flash_u.cfg), 32'h0);
        apb(1'b0, ADDR_RESULT, 32'h0, s);
        chk(s, 32'hB0);
    endtask : t_force
    initial begin
        {i_rst, psel, penable, pwrite, fl_busy} = 5'h10;
        {fl_susp, fl_erase, fl_lock} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_codes();
        t_pin();
        t_refuse();
        t_rst_mid();
        t_force();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
